// ---- include/sltx_map.svh ----
`ifndef SLTX_MAP_SVH
`define SLTX_MAP_SVH

// register byte offsets
`define SLTX_REG_CTRL 4'h0
`define SLTX_REG_STATUS 4'h4
`define SLTX_REG_FRAMES 4'h8

// control register fields and reset value
`define SLTX_CTRL_SOFTSYNC_BIT 0
`define SLTX_CTRL_SWEN_BIT 1
`define SLTX_CTRL_RESET 32'h0000_0002

// status register fields
`define SLTX_STAT_SYNC_BIT 0
`define SLTX_STAT_POWER_BIT 1
`define SLTX_STAT_OE_BIT 2

// symbol framing
`define SLTX_SYM_BITS 12
`define SLTX_CLK_START 1'b1
`define SLTX_CLK_STOP 1'b0
`define SLTX_SYNC_SYMBOL 12'hfc0

// minimum synchronization burst, in symbols
`define SLTX_SYNC_BURST 1024

`endif

// ---- include/sltx_pkg.sv ----
package sltx_pkg;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_DATA,
    ST_SYNC
  } sltx_state_t;

  typedef logic [11:0] sltx_symbol_t;

endpackage : sltx_pkg

// ---- rtl/sltx_sync2.sv ----
`timescale 1ns/10ps
`default_nettype none

module sltx_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  if (WIDTH < 1) begin : g_badWidth
    $error("sltx_sync2: WIDTH must be at least 1");
  end

  // stage1 feeds stage2 only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;

endmodule : sltx_sync2

`default_nettype wire

// ---- rtl/sltx_serializer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sltx_map.svh"

module sltx_serializer
  import sltx_pkg::*;
(
  // link clock and reset
  input wire logic clk,
  input wire logic rst,
  // symbol side
  input wire logic run,
  input wire sltx_symbol_t symbol,
  output logic frameLoad,
  // serial side
  output logic outP,
  output logic outN
);

  localparam logic [3:0] LAST_BIT = 4'(`SLTX_SYM_BITS - 1);

  logic [3:0] bitCnt_r, bitCnt_nxt;
  sltx_symbol_t shift_r, shift_nxt;
  logic outP_r, outP_nxt;
  logic outN_r, outN_nxt;

  // idle counter parks on the last bit so the first running cycle loads
  assign frameLoad = run && (bitCnt_r == LAST_BIT);

  always_comb begin
    bitCnt_nxt = LAST_BIT;
    shift_nxt = shift_r;
    outP_nxt = 1'b0;
    outN_nxt = 1'b1;
    if (run) begin
      if (frameLoad) begin
        bitCnt_nxt = 4'h0;
        outP_nxt = symbol[11];
        shift_nxt = {symbol[10:0], 1'b0};
      end else begin
        bitCnt_nxt = bitCnt_r + 4'h1;
        outP_nxt = shift_r[11];
        shift_nxt = {shift_r[10:0], 1'b0};
      end
      outN_nxt = ~outP_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_r <= LAST_BIT;
      shift_r <= '0;
      outP_r <= 1'b0;
      outN_r <= 1'b1;
    end else begin
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      outP_r <= outP_nxt;
      outN_r <= outN_nxt;
    end
  end

  assign outP = outP_r;
  assign outN = outN_r;

  chk_ser_first_bit: assert property (@(posedge clk) disable iff (rst)
    frameLoad |=> outP_r == $past(symbol[11]) && outN_r != outP_r)
    else $error("serializer did not start the symbol with its first bit");

endmodule : sltx_serializer

`default_nettype wire

// ---- rtl/sltx_top.sv ----
// Summary of operation
// - each active transmit clock edge loads all ten data inputs into a holding register.
// - edge select high strobes data on rising edge, low on falling edge.
// - serial output enable low tri-states both differential outputs.
// - power-down low stops the serializer, tri-states outputs, enters sleep.
// - a synchronization request sends at least 1024 sync symbols.
// - sync symbols continue while the request stays high after the burst.
// - the two synchronization request inputs are ORed together.
// - relock by resent sync symbols, or slower lock to random data.
`timescale 1ns/10ps
`default_nettype none
`include "sltx_map.svh"

module sltx_top
  import sltx_pkg::*;
#(
  parameter int SYNC_BURST = `SLTX_SYNC_BURST
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  // serial bit clock from the transmit pll
  input wire logic serBitClk,
  // parallel pins
  input wire logic transmitClock,
  input wire logic [9:0] txData,
  input wire logic txEdgeSelect,
  // control pins
  input wire logic serialOutEnable,
  input wire logic powerDownN,
  input wire logic syncReqA,
  input wire logic syncReqB,
  // serial output
  output logic serOutP,
  output logic serOutN,
  output logic serOutEn
);

  localparam logic [10:0] BURST_LAST = 11'(SYNC_BURST - 1);

  if (SYNC_BURST < 1 || SYNC_BURST > 2048) begin : g_badBurst
    $error("sltx_top: SYNC_BURST must lie in 1..2048");
  end

  // link domain

  logic [1:0] linkRstPipe_r;
  logic linkRst;

  // reset asserts at once and releases on the bit clock
  always_ff @(posedge serBitClk or posedge rst) begin
    if (rst) begin
      linkRstPipe_r <= 2'b11;
    end else begin
      linkRstPipe_r <= {linkRstPipe_r[0], 1'b0};
    end
  end

  assign linkRst = linkRstPipe_r[1];

  logic [15:0] pinS;
  logic [1:0] ctrlL;
  logic ctrlSoftSync_r;
  logic ctrlSwEnable_r;

  sltx_sync2 #(
    .WIDTH(16)
  ) u_pinSync (
    .clk(serBitClk),
    .rst(linkRst),
    .din({transmitClock, txEdgeSelect, serialOutEnable, powerDownN,
          syncReqA, syncReqB, txData}),
    .dout(pinS)
  );

  sltx_sync2 #(
    .WIDTH(2)
  ) u_ctrlSync (
    .clk(serBitClk),
    .rst(linkRst),
    .din({ctrlSwEnable_r, ctrlSoftSync_r}),
    .dout(ctrlL)
  );

  logic txClkS, edgeSelS, serEnS, pdnS, reqAS, reqBS;
  logic [9:0] dataS;

  assign txClkS = pinS[15];
  assign edgeSelS = pinS[14];
  assign serEnS = pinS[13];
  assign pdnS = pinS[12];
  assign reqAS = pinS[11];
  assign reqBS = pinS[10];
  assign dataS = pinS[9:0];

  logic txClkPrev_r, txClkPrev_nxt;
  logic [9:0] holdWord_r, holdWord_nxt;
  logic strobe;
  logic syncReq;

  // data must stay stable for a few bit clocks past the strobe edge
  assign strobe = edgeSelS ? (txClkS && !txClkPrev_r) : (!txClkS && txClkPrev_r);
  assign syncReq = reqAS || reqBS || ctrlL[0];

  always_comb begin
    txClkPrev_nxt = txClkS;
    holdWord_nxt = holdWord_r;
    if (strobe) begin
      holdWord_nxt = dataS;
    end
  end

  always_ff @(posedge serBitClk or posedge linkRst) begin
    if (linkRst) begin
      txClkPrev_r <= 1'b0;
      holdWord_r <= '0;
    end else begin
      txClkPrev_r <= txClkPrev_nxt;
      holdWord_r <= holdWord_nxt;
    end
  end

  sltx_state_t state_r, state_nxt;
  logic [10:0] burstCnt_r, burstCnt_nxt;
  logic sendSync;
  logic frameTog_r, frameTog_nxt;
  logic serOe_r, serOe_nxt;
  // registered so no state decode glitch reaches the status synchroniser
  logic inSync_r, inSync_nxt;
  logic frameLoad;
  logic run;
  sltx_symbol_t curSymbol;

  assign run = (state_r != ST_OFF) && pdnS;

  always_comb begin
    state_nxt = state_r;
    burstCnt_nxt = burstCnt_r;
    sendSync = 1'b0;
    frameTog_nxt = frameTog_r;
    case (state_r)
      ST_OFF: begin
        burstCnt_nxt = '0;
        if (pdnS) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (frameLoad && syncReq) begin
          sendSync = 1'b1;
          state_nxt = ST_SYNC;
          burstCnt_nxt = BURST_LAST;
        end else if (frameLoad) begin
          frameTog_nxt = ~frameTog_r;
        end
      end
      ST_SYNC: begin
        if (frameLoad) begin
          if (burstCnt_r != 11'h0) begin
            sendSync = 1'b1;
            burstCnt_nxt = burstCnt_r - 11'h1;
          end else if (syncReq) begin
            sendSync = 1'b1;
          end else begin
            state_nxt = ST_DATA;
            frameTog_nxt = ~frameTog_r;
          end
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    // power-down overrides everything and drops a burst in progress
    if (!pdnS) begin
      state_nxt = ST_OFF;
      burstCnt_nxt = '0;
    end
    serOe_nxt = pdnS && (state_nxt != ST_OFF) && serEnS && ctrlL[1];
    inSync_nxt = (state_nxt == ST_SYNC);
  end

  // two clock bits around each payload give a rising edge every symbol
  assign curSymbol = sendSync ? sltx_symbol_t'(`SLTX_SYNC_SYMBOL)
                              : {`SLTX_CLK_START, holdWord_r, `SLTX_CLK_STOP};

  always_ff @(posedge serBitClk or posedge linkRst) begin
    if (linkRst) begin
      state_r <= ST_OFF;
      burstCnt_r <= '0;
      frameTog_r <= 1'b0;
      serOe_r <= 1'b0;
      inSync_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      burstCnt_r <= burstCnt_nxt;
      frameTog_r <= frameTog_nxt;
      serOe_r <= serOe_nxt;
      inSync_r <= inSync_nxt;
    end
  end

  sltx_serializer u_ser (
    .clk(serBitClk),
    .rst(linkRst),
    .run(run),
    .symbol(curSymbol),
    .frameLoad(frameLoad),
    .outP(serOutP),
    .outN(serOutN)
  );

  assign serOutEn = serOe_r;

  // core domain

  logic [2:0] linkStatC;
  logic frameTogPrev_r, frameTogPrev_nxt;
  logic frameEvt;
  logic [31:0] frameCnt_r, frameCnt_nxt;
  logic ctrlSoftSync_nxt, ctrlSwEnable_nxt;
  logic [31:0] regRdData_r, regRdData_nxt;
  logic framesClr;

  sltx_sync2 #(
    .WIDTH(3)
  ) u_statSync (
    .clk(core_clk),
    .rst(rst),
    .din({frameTog_r, serOe_r, inSync_r}),
    .dout(linkStatC)
  );

  assign frameEvt = linkStatC[2] ^ frameTogPrev_r;
  assign framesClr = regWrEn && (regAddr == `SLTX_REG_FRAMES);

  always_comb begin
    frameTogPrev_nxt = linkStatC[2];
    ctrlSoftSync_nxt = ctrlSoftSync_r;
    ctrlSwEnable_nxt = ctrlSwEnable_r;
    if (regWrEn && regAddr == `SLTX_REG_CTRL) begin
      ctrlSoftSync_nxt = regWrData[`SLTX_CTRL_SOFTSYNC_BIT];
      ctrlSwEnable_nxt = regWrData[`SLTX_CTRL_SWEN_BIT];
    end
    // a word sent in the clearing cycle is still counted
    frameCnt_nxt = frameCnt_r;
    if (framesClr) begin
      frameCnt_nxt = frameEvt ? 32'h1 : 32'h0;
    end else if (frameEvt) begin
      frameCnt_nxt = frameCnt_r + 32'h1;
    end
    regRdData_nxt = 32'h0;
    if (regRdEn) begin
      case (regAddr)
        `SLTX_REG_CTRL: begin
          regRdData_nxt[`SLTX_CTRL_SOFTSYNC_BIT] = ctrlSoftSync_r;
          regRdData_nxt[`SLTX_CTRL_SWEN_BIT] = ctrlSwEnable_r;
        end
        `SLTX_REG_STATUS: begin
          regRdData_nxt[`SLTX_STAT_SYNC_BIT] = linkStatC[0];
          regRdData_nxt[`SLTX_STAT_POWER_BIT] = linkStatC[1] || linkStatC[0];
          regRdData_nxt[`SLTX_STAT_OE_BIT] = linkStatC[1];
        end
        `SLTX_REG_FRAMES: begin
          regRdData_nxt = frameCnt_r;
        end
        default: begin
          regRdData_nxt = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frameTogPrev_r <= 1'b0;
      ctrlSoftSync_r <= 1'b0;
      ctrlSwEnable_r <= 1'b1;
      frameCnt_r <= '0;
      regRdData_r <= '0;
    end else begin
      frameTogPrev_r <= frameTogPrev_nxt;
      ctrlSoftSync_r <= ctrlSoftSync_nxt;
      ctrlSwEnable_r <= ctrlSwEnable_nxt;
      frameCnt_r <= frameCnt_nxt;
      regRdData_r <= regRdData_nxt;
    end
  end

  assign regRdData = regRdData_r;

  // checks

  chk_hold_capture: assert property (@(posedge serBitClk) disable iff (linkRst)
    strobe |=> holdWord_r == $past(dataS))
    else $error("holding register missed the strobed data");

  chk_edge_select: assert property (@(posedge serBitClk) disable iff (linkRst)
    (!edgeSelS && txClkS && !txClkPrev_r) |=> holdWord_r == $past(holdWord_r))
    else $error("rising edge captured data while falling edge selected");

  chk_oe_off: assert property (@(posedge serBitClk) disable iff (linkRst)
    !serEnS |=> !serOutEn)
    else $error("serial output driven while output enable low");

  chk_pd_sleep: assert property (@(posedge serBitClk) disable iff (linkRst)
    !pdnS |=> state_r == ST_OFF && !serOutEn && !frameLoad)
    else $error("power-down did not stop and tri-state the link");

  chk_burst_start: assert property (@(posedge serBitClk) disable iff (linkRst)
    (state_r == ST_DATA && frameLoad && syncReq && pdnS)
      |=> state_r == ST_SYNC && burstCnt_r == BURST_LAST)
    else $error("sync request did not start a full burst");

  chk_burst_hold: assert property (@(posedge serBitClk) disable iff (linkRst)
    (state_r == ST_SYNC && burstCnt_r != 11'h0 && pdnS)
      |=> state_r == ST_SYNC)
    else $error("sync burst ended early");

  chk_sync_extend: assert property (@(posedge serBitClk) disable iff (linkRst)
    (state_r == ST_SYNC && frameLoad && syncReq && pdnS) |-> sendSync
      ##1 state_r == ST_SYNC)
    else $error("sync stopped while request still high");

  chk_req_or: assert property (@(posedge serBitClk) disable iff (linkRst)
    (state_r == ST_DATA && frameLoad && reqBS && !reqAS && pdnS) |=> state_r == ST_SYNC)
    else $error("second request input was not ORed in");

  chk_clock_bits: assert property (@(posedge serBitClk) disable iff (linkRst)
    frameLoad |-> curSymbol[11] && !curSymbol[0])
    else $error("symbol lacks its embedded clock bits");

  chk_frame_count: assert property (@(posedge core_clk) disable iff (rst)
    (frameEvt && !framesClr) |=> frameCnt_r == $past(frameCnt_r) + 32'h1)
    else $error("frame counter missed a sent word");

  cov_sync_entry: cover property (@(posedge serBitClk) disable iff (linkRst)
    state_r == ST_DATA ##1 state_r == ST_SYNC);

  cov_sync_extend: cover property (@(posedge serBitClk) disable iff (linkRst)
    state_r == ST_SYNC && burstCnt_r == 11'h0 && frameLoad && syncReq);

  cov_falling_strobe: cover property (@(posedge serBitClk) disable iff (linkRst)
    strobe && !edgeSelS);

  cov_power_down: cover property (@(posedge serBitClk) disable iff (linkRst)
    state_r == ST_DATA ##1 state_r == ST_OFF);

endmodule : sltx_top

`default_nettype wire

// ---- dv/sltx_rx_model.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sltx_map.svh"

module sltx_rx_model (
  // link side
  input wire logic bitClk,
  input wire logic rst,
  input wire logic lineP,
  input wire logic lineEn,
  // recovered side
  output logic lockN,
  output logic wordStb,
  output logic [9:0] word,
  output logic frameBad,
  output int lastRun,
  output int runCnt
);
  logic [11:0] sr;
  logic [11:0] f;
  logic rxBit;
  int bitCnt;
  int badRun;
  int syncCnt;
  int relCnt;

  // released line: a moving pattern, so no stale bit passes for data
  assign rxBit = lineEn ? lineP : (relCnt < 3);

  // sample mid-bit, away from the driver's edge
  always @(negedge bitClk or posedge rst) begin
    if (rst) begin
      lockN <= 1'b1;
      sr <= '0;
      relCnt <= 0;
      bitCnt <= 0;
      badRun <= 0;
      syncCnt <= 0;
      lastRun <= 0;
      runCnt <= 0;
      wordStb <= 1'b0;
      frameBad <= 1'b0;
      word <= '0;
    end else begin
      f = {sr[10:0], rxBit};
      sr <= f;
      relCnt <= (relCnt == 4) ? 0 : relCnt + 1;
      wordStb <= 1'b0;
      frameBad <= 1'b0;
      bitCnt <= (bitCnt == 11) ? 0 : bitCnt + 1;
      if (lockN && f == `SLTX_SYNC_SYMBOL) begin
        lockN <= 1'b0;
        bitCnt <= 0;
      end else if (!lockN && bitCnt == 11) begin
        if (f[11] == `SLTX_CLK_START && f[0] == `SLTX_CLK_STOP) begin
          badRun <= 0;
          if (f == `SLTX_SYNC_SYMBOL) begin
            syncCnt <= syncCnt + 1;
          end else begin
            if (syncCnt > 0) begin
              lastRun <= syncCnt;
              runCnt <= runCnt + 1;
            end
            syncCnt <= 0;
            word <= f[10:1];
            wordStb <= 1'b1;
          end
        end else begin
          frameBad <= 1'b1;
          badRun <= badRun + 1;
          // three words before the unlock are untrusted; the bench drops its history
          if (badRun == 3) begin
            lockN <= 1'b1;
            badRun <= 0;
            syncCnt <= 0;
          end
        end
      end
    end
  end
endmodule : sltx_rx_model

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sltx_map.svh"

module tb_top;
  localparam int SB = 8;
  logic core_clk, rst, serBitClk, transmitClock, txEdgeSelect, serialOutEnable, powerDownN;
  logic syncReqA, tbReqB, regWrEn, regRdEn, serOutP, serOutN, serOutEn, lockN;
  logic wordStb, frameBad, checkOn, havePrev;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData, rdv;
  logic [9:0] txData, nextWord, prevWord, word;
  int lastRun, runCnt, ph, nWords, n0, n_mismatch, n_compared;
  wire logic syncReqB;

  assign syncReqB = tbReqB | lockN;

  sltx_top #(.SYNC_BURST(SB)) DUT (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .serBitClk(serBitClk), .transmitClock(transmitClock), .txData(txData),
    .txEdgeSelect(txEdgeSelect), .serialOutEnable(serialOutEnable), .powerDownN(powerDownN),
    .syncReqA(syncReqA), .syncReqB(syncReqB), .serOutP(serOutP), .serOutN(serOutN),
    .serOutEn(serOutEn));

  sltx_rx_model partner (.bitClk(serBitClk), .rst(rst), .lineP(serOutP), .lineEn(serOutEn),
    .lockN(lockN), .wordStb(wordStb), .word(word), .frameBad(frameBad),
    .lastRun(lastRun), .runCnt(runCnt));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    serBitClk = 1'b0;
    #3;
    forever #16 serBitClk = ~serBitClk;
  end

  function automatic logic [9:0] nxt(input logic [9:0] w);
    nxt = w + 10'h155;
    // skip the one word that looks like a sync symbol on the wire
    if (nxt == 10'h3e0) nxt = nxt + 10'h155;
  endfunction : nxt

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    rdv = regRdData;
  endtask : rd

  task automatic syms(input int n);
    repeat (n * 12) @(posedge serBitClk);
    #2;
  endtask : syms

  task automatic waitLock(input logic v);
    int i;
    for (i = 0; i < 20000 && lockN !== v; i++) @(posedge core_clk);
    chk("lock indicator", {31'h0, v}, {31'h0, lockN});
    if (lockN !== v) close_out();
  endtask : waitLock

  // sources 0..2 request sync, 3..5 turn the output off when low
  task automatic drive(input int k, input logic v);
    @(posedge core_clk);
    case (k)
      0: syncReqA <= v;
      1: tbReqB <= v;
      2: wr(`SLTX_REG_CTRL, {30'h0, 1'b1, v});
      3: serialOutEnable <= v;
      4: wr(`SLTX_REG_CTRL, {30'h0, v, 1'b0});
      default: powerDownN <= v;
    endcase
  endtask : drive

  task automatic burst(input int k, input int hold, input int lo, input int hi);
    int r;
    int i;
    int g;
    r = runCnt;
    drive(k, 1'b1);
    syms(hold);
    rd(`SLTX_REG_STATUS);
    chk("status sync", 32'h1, rdv & 32'h1);
    drive(k, 1'b0);
    for (i = 0; i < 100 && runCnt == r; i++) syms(1);
    // a run that never ends reads as -1 and fails
    g = (runCnt == r) ? -1 : lastRun;
    chk("sync run", lo, (g >= lo && g <= hi) ? lo : g);
    if (runCnt == r) close_out();
  endtask : burst

  // host pins: word valid only around the active edge, complemented elsewhere
  always @(posedge serBitClk) begin
    ph = (ph == 11) ? 0 : ph + 1;
    if (ph == 9) nextWord = nxt(nextWord);
    // twelve bit clocks per word: the scaled stand-in for the 20 to 80 MHz host clock
    transmitClock <= (ph < 6) ~^ txEdgeSelect;
    txData <= (ph >= 9 || ph < 4) ? nextWord : ~nextWord;
    if (wordStb && checkOn && havePrev) begin
      chk("serial word", {22'h0, nxt(prevWord)}, {22'h0, word});
    end
    if (frameBad && checkOn) chk("frame clock bits", 32'h0, 32'h1);
    if (checkOn && serOutEn) chk("pair", {31'h0, ~serOutP}, {31'h0, serOutN});
    if (wordStb && checkOn) nWords++;
    havePrev <= checkOn && (wordStb || havePrev);
    if (wordStb) prevWord <= word;
  end

  initial begin
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 32'h0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    transmitClock = 1'b0;
    txData = 10'h000;
    txEdgeSelect = 1'b1;
    serialOutEnable = 1'b1;
    powerDownN = 1'b1;
    syncReqA = 1'b0;
    tbReqB = 1'b0;
    checkOn = 1'b0;
    havePrev = 1'b0;
    prevWord = 10'h000;
    nextWord = 10'h001;
    ph = 0;
    nWords = 0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge serBitClk);
    @(posedge core_clk);
    rst <= 1'b0;
    rd(`SLTX_REG_CTRL);
    chk("ctrl reset", `SLTX_CTRL_RESET, rdv);
    waitLock(1'b0);
    syms(12);
    wr(`SLTX_REG_STATUS, 32'h0);
    rd(`SLTX_REG_STATUS);
    chk("status", 32'h6, rdv & 32'h7);
    rd(4'hc);
    chk("unmapped", 32'h0, rdv);
    for (int e = 1; e >= 0; e--) begin
      drive(6, 1'b1);
      txEdgeSelect <= e[0];
      syms(4);
      checkOn <= 1'b1;
      n0 = nWords;
      syms(40);
      chk("words seen", 32'h1, {31'h0, (nWords - n0) > 36});
      checkOn <= 1'b0;
    end
    wr(`SLTX_REG_FRAMES, 32'h0);
    syms(10);
    rd(`SLTX_REG_FRAMES);
    chk("frame count", 32'h1, {31'h0, rdv >= 9 && rdv <= 11});
    for (int s = 0; s < 3; s++) burst(s, 2, SB, SB);
    burst(1, 30, SB + 20, 40);
    for (int m = 3; m < 6; m++) begin
      drive(m, 1'b0);
      syms(2);
      chk("output enable", 32'h0, {31'h0, serOutEn});
      rd(`SLTX_REG_STATUS);
      chk("status off", 32'h0, rdv & ((m == 5) ? 32'h6 : 32'h4));
      waitLock(1'b1);
      drive(m, 1'b1);
      waitLock(1'b0);
      chk("output enable", 32'h1, {31'h0, serOutEn});
    end
    close_out();
  end
endmodule : tb_top

`default_nettype wire
